// ==== src/sah_ctrl.sv ====
// Bus controller that sends arbitrable and push-pull address headers
`timescale 1ns/1ps
module sah_ctrl
   import sah_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic cmd_valid, // Command offered
   output logic cmd_ready, // Command can be taken
   input wire logic cmd_stop, // 1 = stop, 0 = header
   input wire logic [6:0] cmd_addr, // Header address
   input wire logic cmd_rnw, // Header direction bit
   input wire logic cmd_pp_opt, // Allow push-pull speed-up
   input wire logic cmd_legacy, // Legacy devices addressed
   input wire logic req_accept, // Acknowledge a won request
   output logic scl_o, // Clock level
   output logic scl_oe_b, // Clock drive enable, low drives
   input wire logic sda_i, // Data wire level
   output logic sda_o, // Data drive level
   output logic sda_oe_b, // Data drive enable, low drives
   output logic busy, // Frame in progress
   output logic done, // Header finished pulse
   output logic acked, // Header was acknowledged
   output logic arb_lost, // A target won arbitration
   output logic [6:0] req_addr, // Address seen on the wire
   output logic req_rnw // Direction bit seen on the wire
);
   sah_q_s q;
   sah_q_s n;
   logic scl_oe_b_q;

   // ---------------------------------------------------------------
   // Data drive for one bit
   // ---------------------------------------------------------------
   // Returns {oe_b, level}; open-drain never drives a one
   function automatic logic [1:0] sda_set(input logic [3:0] idx, input logic b,
                                          input logic pp, input logic lost,
                                          input logic ackdrv);
      logic [1:0] r;
      r = 2'h2;
      if (idx == IDX_ACK) begin
         r = ackdrv ? 2'h0 : 2'h2;
      end else if (lost) begin
         r = 2'h2;
      end else if (pp) begin
         r = {1'b0, b};
      end else begin
         r = {b, 1'b0};
      end
      return r;
   endfunction

   function automatic logic [7:0] lo_len(input logic leg);
      return leg ? LEG_CYC : OD_LO_CYC;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic s;
      logic [1:0] d;
      n = q;
      s = q.sy1;
      d = 2'h2;
      n.sy0 = sda_i;
      n.sy1 = q.sy0;
      n.done = 1'b0;
      if (q.cnt != 8'h00) begin
         n.cnt = q.cnt - 8'h01;
      end else begin
         case (q.st)
            S_IDLE: begin
               n.scl_o = 1'b1;
               n.sda_oe_b = 1'b1;
               if (!s) begin
                  // Target pulled data low on a free bus: overlap it
                  n.st = S_START;
                  n.hdr = {ADDR_BCAST, 1'b0};
                  n.leg = 1'b0;
                  n.popt = 1'b0;
               end else if (cmd_valid && !cmd_stop) begin
                  n.st = S_START;
                  n.hdr = {cmd_addr, cmd_rnw};
                  n.leg = cmd_legacy;
                  n.popt = cmd_pp_opt;
               end
               if (n.st == S_START) begin
                  n.sda_o = 1'b0;
                  n.sda_oe_b = 1'b0;
                  n.rs = 1'b0;
                  n.pp = 1'b0;
                  n.cnt = lo_len(n.leg) - 8'h01;
               end
            end
            S_START: begin
               n.scl_o = 1'b0;
               n.st = S_BIT_LO;
               n.idx = IDX_A6;
               n.sh = q.hdr;
               n.lost = 1'b0;
               n.ackdrv = 1'b0;
               n.pp = q.rs;
               d = sda_set(IDX_A6, q.hdr[7], q.rs, 1'b0, 1'b0);
               n.sda_oe_b = d[1];
               n.sda_o = d[0];
               n.cnt = lo_len(q.leg) - 8'h01;
            end
            S_BIT_LO: begin
               n.scl_o = 1'b1;
               n.st = S_BIT_HI;
               n.cnt = (q.leg ? LEG_CYC : HI_FAST_CYC) - 8'h01;
            end
            S_BIT_HI: begin
               n.scl_o = 1'b0;
               if (q.idx < IDX_ACK) begin
                  n.rx = {q.rx[6:0], s};
                  if (!q.pp && q.sh[7] && !s) begin
                     n.lost = 1'b1;
                  end
                  // Nobody can drive a one on the first bit, so high is safe
                  if (q.idx == IDX_A6 && !q.rs && q.popt && q.sh[7] && s) begin
                     n.pp = 1'b1;
                  end
                  n.sh = {q.sh[6:0], 1'b0};
                  n.idx = q.idx + 4'h1;
                  n.ackdrv = n.lost && req_accept;
                  d = sda_set(n.idx, n.sh[7], n.pp, n.lost, n.ackdrv);
                  n.sda_oe_b = d[1];
                  n.sda_o = d[0];
                  n.st = S_BIT_LO;
                  n.cnt = lo_len(q.leg) - 8'h01;
               end else begin
                  n.sda_oe_b = 1'b1;
                  n.pp = 1'b0;
                  n.st = S_HOLD;
                  n.cnt = lo_len(q.leg) - 8'h01;
                  if (!q.lost && s && !q.rs && q.hdr[7:1] != ADDR_BCAST) begin
                     n.resend = 1'b1;
                  end else begin
                     n.done = 1'b1;
                     n.acked = !s;
                     n.arb_lost = q.lost;
                  end
               end
            end
            S_HOLD: begin
               if (q.resend) begin
                  n.resend = 1'b0;
                  n.st = S_RS_A;
               end else if (cmd_valid) begin
                  if (cmd_stop) begin
                     n.st = S_SP_A;
                     n.sda_o = 1'b0;
                     n.sda_oe_b = 1'b0;
                  end else begin
                     n.st = S_RS_A;
                     n.hdr = {cmd_addr, cmd_rnw};
                     n.leg = cmd_legacy;
                     n.popt = cmd_pp_opt;
                  end
               end
               if (n.st != S_HOLD) begin
                  n.cnt = lo_len(n.leg) - 8'h01;
               end
            end
            S_RS_A: begin
               // Drive high so the following fall is a clean repeated start
               n.sda_o = 1'b1;
               n.sda_oe_b = 1'b0;
               n.st = S_RS_B;
               n.cnt = lo_len(q.leg) - 8'h01;
            end
            S_RS_B: begin
               n.scl_o = 1'b1;
               n.st = S_START;
               n.rs = 1'b1;
               n.cnt = lo_len(q.leg) - 8'h01;
            end
            S_SP_A: begin
               n.scl_o = 1'b1;
               n.st = S_SP_B;
               n.cnt = lo_len(q.leg) - 8'h01;
            end
            S_SP_B: begin
               n.sda_oe_b = 1'b1;
               n.st = S_SP_C;
               n.cnt = BUF_CYC - 8'h01;
            end
            S_SP_C: begin
               n.st = S_IDLE;
            end
            default: begin
               n.st = S_IDLE;
            end
         endcase
      end
      if (q.st == S_START && q.cnt == 8'h01) begin
         n.sda_o = 1'b0;
         n.sda_oe_b = 1'b0;
      end
      n.busy = (n.st != S_IDLE);
      n.ready = (n.st == S_IDLE || (n.st == S_HOLD && !n.resend)) &&
                n.cnt == 8'h00;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.st <= S_IDLE;
         q.sy0 <= 1'b1;
         q.sy1 <= 1'b1;
         q.scl_o <= 1'b1;
         q.sda_o <= 1'b1;
         q.sda_oe_b <= 1'b1;
         scl_oe_b_q <= 1'b0;
      end else begin
         q <= n;
         scl_oe_b_q <= 1'b0;
      end
   end

   assign cmd_ready = q.ready;
   assign scl_o = q.scl_o;
   assign scl_oe_b = scl_oe_b_q;
   assign sda_o = q.sda_o;
   assign sda_oe_b = q.sda_oe_b;
   assign busy = q.busy;
   assign done = q.done;
   assign acked = q.acked;
   assign arb_lost = q.arb_lost;
   assign req_addr = q.rx[7:1];
   assign req_rnw = q.rx[0];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   logic ph;
   assign ph = (q.st == S_BIT_LO || q.st == S_BIT_HI);

   a_target_start: assert property ((q.st == S_IDLE && q.cnt == 8'h00 && !q.sy1)
      |=> (!q.sda_o && !q.sda_oe_b) ##[1:300] !q.scl_o)
      else $error("target start not overlapped");
   a_idx_cleared: assert property ((q.st == S_START && q.cnt == 8'h00)
      |=> q.idx == IDX_A6 && q.st == S_BIT_LO)
      else $error("bit counter not cleared at start");
   a_rs_push_pull: assert property ((ph && q.rs && q.idx < IDX_ACK) |-> !q.sda_oe_b)
      else $error("repeated start header not push-pull");
   a_ack_released: assert property ((ph && q.idx == IDX_ACK && !q.ackdrv) |-> q.sda_oe_b)
      else $error("acknowledge bit driven");
   a_first_bit_od: assert property ((ph && !q.rs && q.idx == IDX_A6)
      |-> (q.sda_oe_b || !q.sda_o) && !q.pp)
      else $error("first arbitrable bit driven high");
   a_zero_held: assert property ((ph && !q.pp && !q.lost && q.idx < IDX_ACK && !q.sh[7])
      |-> !q.sda_oe_b && !q.sda_o)
      else $error("zero bit not held low");
   a_loss_caught: assert property ((q.st == S_BIT_HI && q.cnt == 8'h00 && q.idx < IDX_ACK
      && !q.pp && q.sh[7] && !q.sy1) |=> q.lost)
      else $error("arbitration loss missed");
   a_lost_quiet: assert property ((ph && q.lost && q.idx < IDX_ACK) |-> q.sda_oe_b)
      else $error("driving after lost arbitration");
   a_fast_high: assert property ((q.st == S_BIT_HI && !q.leg) |-> q.cnt < HI_FAST_CYC)
      else $error("clock high too long");
   a_ack_outcome: assert property ((q.st == S_BIT_HI && q.cnt == 8'h00 && q.idx == IDX_ACK)
      |=> (q.done || q.resend) && q.st == S_HOLD)
      else $error("header end not reported");
   a_resend_rs: assert property ($rose(q.resend) |-> ##[1:300] q.st == S_RS_B)
      else $error("ambiguous header not resent");
   a_pp_needs_high: assert property ((q.st == S_BIT_HI && q.cnt == 8'h00 && q.idx == IDX_A6
      && !q.rs && !(q.popt && q.sh[7] && q.sy1)) |=> !q.pp)
      else $error("push-pull without a free first bit");
   a_done_pulse: assert property (q.done |=> !q.done)
      else $error("done longer than one cycle");
   a_rs_fall: assert property ((q.st == S_START && q.cnt == 8'h01)
      |=> !q.sda_o && !q.sda_oe_b && q.scl_o)
      else $error("start edge not made with clock high");
   a_resend_once: assert property ((q.st == S_BIT_HI && q.cnt == 8'h00 && q.idx == IDX_ACK
      && q.rs) |=> !q.resend)
      else $error("resend after repeated start");
   a_leg_high: assert property ((q.st == S_BIT_LO && q.cnt == 8'h00 && q.leg)
      |=> q.cnt == LEG_CYC - 8'h01)
      else $error("legacy clock high too short");
   a_ack_drive: assert property ((ph && q.idx == IDX_ACK && q.ackdrv)
      |-> !q.sda_oe_b && !q.sda_o && q.lost)
      else $error("acknowledge driven without a won request");
   a_idle_free: assert property ((q.st == S_IDLE && q.cnt == 8'h00 && q.sy1 && !cmd_valid)
      |=> q.sda_oe_b && q.scl_o)
      else $error("free bus not left released");


   c_lost: cover property (q.done && q.arb_lost);
   c_resend: cover property ($rose(q.resend));
   c_target_start: cover property (q.st == S_IDLE && !q.sy1 ##1 q.st == S_START);
   c_push_pull: cover property (ph && q.pp && !q.rs);
   c_legacy: cover property (q.done && q.leg);
endmodule

// ==== src/sah_pkg.sv ====
// Constants, states and state record for the address header bus controller
// ---------------------------------------------------------------
// How it works
// - Header is seven address bits, direction bit, acknowledge bit.
// - Header after start: start, first bit, acknowledge open-drain; rest may push-pull.
// - Header after repeated start is push-pull except the acknowledge.
// - On target start controller pulls clock low and overlaps data low.
// - Zero bit: drive data low from clock fall to next fall.
// - One bit: release data at fall, sample at next rise.
// - Low seen while sending one loses; send no more of that header.
// - Capable targets get lower-half addresses so first bit is zero.
// - Controller sent one, saw high: rest may push-pull; else open-drain.
// - New-protocol only: clock high below 50 ns; legacy: slow timing.
// - Broadcast or static opening: watch requests, then accept or refuse.
// - Dynamic address collision: writing controller wins, reading one loses.
// - Full coincidence gives no acknowledge; resend address after repeated start.
// ---------------------------------------------------------------
package sah_pkg;
   localparam int CLK_NS = 20;
   localparam int T_OD_LO_NS = 200;
   localparam int T_HI_FAST_NS = 40;
   localparam int T_LEG_HALF_NS = 1300;
   localparam int T_BUF_NS = 1300;
   localparam logic [7:0] OD_LO_CYC = 8'((T_OD_LO_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] HI_FAST_CYC = 8'((T_HI_FAST_NS / CLK_NS) < 1 ? 1 :
                                          (T_HI_FAST_NS / CLK_NS));
   localparam logic [7:0] LEG_CYC = 8'((T_LEG_HALF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] BUF_CYC = 8'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [6:0] ADDR_BCAST = 7'h7E;
   localparam logic [6:0] ADDR_JOIN = 7'h02;
   localparam logic [3:0] IDX_A6 = 4'h0;
   localparam logic [3:0] IDX_ACK = 4'h8;

   typedef enum logic [3:0] {
      S_IDLE, S_START, S_BIT_LO, S_BIT_HI, S_HOLD,
      S_RS_A, S_RS_B, S_SP_A, S_SP_B, S_SP_C
   } sah_state_e;

   typedef struct packed {
      sah_state_e st;
      logic [7:0] cnt;
      logic [3:0] idx;
      logic [7:0] sh;
      logic [7:0] hdr;
      logic [7:0] rx;
      logic rs;
      logic pp;
      logic lost;
      logic ackdrv;
      logic leg;
      logic popt;
      logic resend;
      logic sy0;
      logic sy1;
      logic scl_o;
      logic sda_o;
      logic sda_oe_b;
      logic done;
      logic acked;
      logic arb_lost;
      logic busy;
      logic ready;
   } sah_q_s;
endpackage

// ==== tb/sah_ctrl_tb_top.sv ====
// Self-checking bench for the address header controller
`timescale 1ns/1ps
module sah_ctrl_tb_top
   import sah_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_valid = 1'b0, cmd_stop = 1'b0, cmd_rnw = 1'b0, cmd_pp_opt = 1'b0;
   logic cmd_legacy = 1'b0, req_accept = 1'b0, req_on = 1'b0, self_start = 1'b0;
   logic [6:0] cmd_addr = 7'h00, dyn = 7'h12, req_addr;
   logic [7:0] thdr = 8'h00;
   logic cmd_ready, scl_o, scl_oe_b, sda_o, sda_oe_b, busy, done, acked, arb_lost, req_rnw;
   logic tgt_low;
   int errors = 0, checks = 0, pp_hi = 0, run = 0, last_hi = 0;
   // Pull-up on both wires
   wire logic sda = (sda_oe_b ? 1'b1 : sda_o) & ~tgt_low;
   wire logic scl = scl_oe_b ? 1'b1 : scl_o;
   always #10 sys_clk = ~sys_clk;
   sah_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_stop(cmd_stop), .cmd_addr(cmd_addr), .cmd_rnw(cmd_rnw),
      .cmd_pp_opt(cmd_pp_opt), .cmd_legacy(cmd_legacy), .req_accept(req_accept),
      .scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
      .busy(busy), .done(done), .acked(acked), .arb_lost(arb_lost), .req_addr(req_addr),
      .req_rnw(req_rnw));
   sah_tgt_model tgt_u (.scl(scl), .sda(sda), .dyn_addr(dyn), .req_on(req_on),
      .req_hdr(thdr), .self_start(self_start), .sda_low(tgt_low));
   // Push-pull high cycles and length of the last clock high pulse
   always @(posedge sys_clk) begin
      if (!sda_oe_b && sda_o && scl_o) pp_hi <= pp_hi + 1;
      if (scl_o) run <= run + 1;
      else if (run != 0) begin
         last_hi <= run;
         run <= 0;
      end
   end
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (exp !== got) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      if (errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic issue(input logic s, input logic [6:0] a, input logic r);
      int n;
      n = 0;
      @(negedge sys_clk);
      cmd_stop = s;
      cmd_addr = a;
      cmd_rnw = r;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      if (n >= 5000) errors++;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 5000) errors++;
   endtask
   task automatic stop_frame();
      int n;
      n = 0;
      issue(1'b1, 7'h00, 1'b0);
      while (busy !== 1'b0 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 5000) errors++;
      req_on = 1'b0;
   endtask
   function automatic logic addressed(input logic [7:0] c);
      return c[7:1] == dyn || c[7:1] == ADDR_BCAST;
   endfunction
   // One header, against a target that may request; rs marks a header after repeated start
   task automatic hdr_case(input logic [7:0] c, input logic t, input logic [7:0] h,
      input logic pp, input logic leg, input logic acc, input logic rs, input logic ss);
      logic lose, resend;
      logic [7:0] w;
      lose = t && !rs && h < c;
      resend = !lose && !rs && c[7:1] != ADDR_BCAST && (!addressed(c) || (t && h == c));
      w = lose ? h : c;
      req_on = t;
      thdr = h;
      cmd_pp_opt = pp;
      cmd_legacy = leg;
      req_accept = acc;
      pp_hi = 0;
      if (ss) self_start = 1'b1;
      else issue(1'b0, c[7:1], c[0]);
      wait_done();
      self_start = 1'b0;
      chk("req_addr", {1'b0, w[7:1]}, {1'b0, req_addr});
      chk("req_rnw", 8'(w[0]), 8'(req_rnw));
      chk("arb_lost", 8'(lose), 8'(arb_lost));
      chk("acked", 8'(lose ? acc : addressed(c)), 8'(acked));
      chk("push_pull", 8'((pp && c[7] && !(t && !rs)) || resend || rs), 8'(pp_hi != 0));
      chk("high_time", leg ? LEG_CYC : HI_FAST_CYC, 8'(last_hi));
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      logic [7:0] c, h;
      void'($urandom(16));
      repeat (4) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("idle_ready", 8'h01, 8'(cmd_ready));
      hdr_case({ADDR_BCAST, 1'b0}, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      stop_frame();
      hdr_case({ADDR_BCAST, 1'b0}, 1'b1, {dyn, 1'b1}, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      stop_frame();
      hdr_case({ADDR_BCAST, 1'b0}, 1'b1, {dyn, 1'b0}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      stop_frame();
      hdr_case({ADDR_BCAST, 1'b0}, 1'b1, {ADDR_JOIN, 1'b0}, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      stop_frame();
      hdr_case({dyn, 1'b0}, 1'b1, {dyn, 1'b1}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      stop_frame();
      hdr_case({dyn, 1'b1}, 1'b1, {dyn, 1'b0}, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      stop_frame();
      hdr_case({dyn, 1'b1}, 1'b1, {dyn, 1'b1}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      hdr_case({dyn, 1'b0}, 1'b1, {dyn, 1'b1}, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      stop_frame();
      hdr_case({7'h55, 1'b0}, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      stop_frame();
      hdr_case({ADDR_BCAST, 1'b0}, 1'b1, {dyn, 1'b1}, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      stop_frame();
      for (int i = 0; i < 12; i++) begin
         dyn = 7'($urandom_range(8'h3D, 8'h08));
         h = {($urandom_range(1) != 0) ? dyn : ADDR_JOIN, 1'($urandom_range(1))};
         case ($urandom_range(2))
            0: c = {ADDR_BCAST, 1'b0};
            1: c = {dyn, 1'($urandom_range(1))};
            default: c = 8'($urandom());
         endcase
         hdr_case(c, 1'($urandom_range(1)), h, 1'($urandom_range(1)),
            1'($urandom_range(1)), 1'($urandom_range(1)), 1'b0, 1'b0);
         stop_frame();
      end
      summarize();
   end
   // Whole run needs well under 60k cycles; this cuts a hang short
   initial begin
      #2_000_000;
      errors++;
      summarize();
   end
endmodule

// ==== tb/sah_tgt_model.sv ====
// Behavioural model of the targets that share the data wire
`timescale 1ns/1ps
module sah_tgt_model
   import sah_pkg::*;
(
   input wire logic scl, // Bus clock
   input wire logic sda, // Resolved data wire
   input wire logic [6:0] dyn_addr, // Own dynamic address
   input wire logic req_on, // Request wanted, level
   input wire logic [7:0] req_hdr, // Request address and direction
   input wire logic self_start, // Open a frame on a free bus
   output logic sda_low // High pulls data low
);
   logic in_frame = 1'b0;
   logic rs = 1'b0;
   logic sending = 1'b0;
   logic lost = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] seen = 8'h00;
   initial sda_low = 1'b0;
   // ---------------------------------------------
   // Frame edges
   // ---------------------------------------------
   // Data may move in the same step as the clock falls; judge once the clock has settled
   always @(negedge sda) begin
      #1;
      if (scl) begin
         rs = in_frame;
         in_frame = 1'b1;
         cnt = 4'h0;
         lost = 1'b0;
         sending = req_on && !rs;
      end
   end
   always @(posedge sda) begin
      #1;
      if (scl) begin
         in_frame = 1'b0;
         sending = 1'b0;
      end
   end
   // Only a free bus may be opened by us; the controller must take over the clock
   always @(posedge self_start) begin
      if (!in_frame && scl && sda) sda_low = 1'b1;
   end
   // ---------------------------------------------
   // Header bits, open-drain only
   // ---------------------------------------------
   always @(negedge scl) begin
      if (in_frame) begin
         if (cnt < 4'h8) sda_low = sending && !lost && !req_hdr[4'h7 - cnt];
         else if (cnt == 4'h8) sda_low = (!sending || lost) &&
            (seen[7:1] == dyn_addr || seen[7:1] == ADDR_BCAST);
         else sda_low = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (in_frame && cnt < 4'h9) begin
         if (cnt < 4'h8) seen = {seen[6:0], sda};
         if (cnt < 4'h8 && sending && req_hdr[4'h7 - cnt] && !sda) lost = 1'b1;
         cnt = cnt + 4'h1;
      end
   end
endmodule
